/* File: shared/mpr_pkg.sv */
// Constants for the mixer and synthesizer control word bank.
// Assumes a 16-bit word per address and a seven-bit word address.
package mpr_pkg;

   // -----------------------------------------------------------------
   // Serial frame layout
   // -----------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam logic [4:0] HEAD_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h18;

   // -----------------------------------------------------------------
   // Word addresses and reset values
   // -----------------------------------------------------------------
   localparam logic [6:0] ADDR_RESTART = 7'h00;
   localparam logic [6:0] ADDR_REVISION_B = 7'h7e;
   localparam logic [6:0] ADDR_PRODUCT_B = 7'h7f;
   localparam int REG_COUNT = 13;
   localparam int IDX_POWER = 0;
   localparam int IDX_INT = 1;
   localparam int IDX_FRAC = 2;
   localparam int IDX_MOD = 3;
   localparam int IDX_IFBIAS = 4;
   localparam int IDX_PUMP = 5;
   localparam int IDX_PFDA = 6;
   localparam int IDX_OSC = 7;
   localparam int IDX_BALUN = 8;
   localparam int IDX_PFDB = 9;
   localparam logic [6:0] REG_ADDR [REG_COUNT] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h10,
      7'h20, 7'h21, 7'h22, 7'h30, 7'h40, 7'h42, 7'h43, 7'h44};
   localparam logic [15:0] REG_RESET [REG_COUNT] = '{16'h0000, 16'h0058, 16'h0250,
      16'h0600, 16'h02b5, 16'h0026, 16'h0003, 16'h000a, 16'h0000, 16'h0010, 16'h000e,
      16'h0001, 16'h0000};

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int PWR_LO_REG = 15;
   localparam int PWR_LO2 = 14;
   localparam int PWR_BALUN = 13;
   localparam int PWR_LO1 = 12;
   localparam int PWR_DIV_REG = 11;
   localparam int PWR_RX_LSB = 9;
   localparam int PWR_EXT_LO = 8;
   localparam int PWR_LO_DRV = 7;
   localparam int PWR_OSC_BUF = 6;
   localparam int PWR_REF_BUF = 5;
   localparam int PWR_OSC = 4;
   localparam int PWR_DIVIDERS = 3;
   localparam int PWR_PUMP = 2;
   localparam int PWR_OSC_REG = 1;
   localparam int PWR_MAIN_REG = 0;
   localparam int INT_MODE_BIT = 15;
   localparam int IF_LIN_EFF_BIT = 15;
   localparam int IF_MAIN_EFF_BIT = 14;
   localparam int IF_LIN_SLOPE_LSB = 12;
   localparam int IF_MAIN_SLOPE_LSB = 10;
   localparam int IF_LIN_BIAS_LSB = 6;
   localparam int IF_LIN_INT_BIT = 5;
   localparam int IF_MAIN_BIAS_LSB = 1;
   localparam int IF_MAIN_INT_BIT = 0;
   localparam int PUMP_SCALE_LSB = 8;
   localparam int PUMP_BLEED_POL_BIT = 7;
   localparam int REF_OUT_LSB = 13;
   localparam int DET_POL_BIT = 12;
   localparam int LO_LEVEL_LSB = 6;
   localparam int LO_DIV_LSB = 3;
   localparam int BAL_GATE_LSB = 11;
   localparam int BAL_FILTER_LSB = 8;
   localparam int BALUN_OUTPUT_CAPACITANCE_LSB = 4;
   localparam int PUMP_CTRL_LSB = 2;
   localparam logic [2:0] OSC_EXTERNAL = 3'h6;
   localparam logic [3:0] OSC_CORE_RESET = 4'h4;
   localparam logic [7:0] REF_ROUTE_RESET = 8'h01;

endpackage

/* File: shared/mpr_port_if.sv */
// Word transfer carrier between the serial port and the word bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface mpr_port_if import mpr_pkg::*; ();
   // Word address of the current frame, held until the next frame.
   logic [ADDR_W-1:0] addr;
   // Write data and its one-cycle strobe.
   logic [DATA_W-1:0] wrData;
   logic wrStb;
   // Read value for the held address.
   logic [DATA_W-1:0] rdData;

   modport port (output addr, output wrData, output wrStb, input rdData);
   modport bank (input addr, input wrData, input wrStb, output rdData);
endinterface

/* File: hw/mpr_serial_port.sv */
// Three-wire serial slave: takes frames and presents words to the bank.
// Assumes the serial clock is much slower than sys_clk and idles low.
`timescale 1ns/1ps
module mpr_serial_port import mpr_pkg::*; (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Serial pins.
   input wire logic serialClk,
   input wire logic chipSelectN,
   input wire logic sdioIn,
   output logic sdioOut,
   output logic sdioOe,
   // Word side.
   mpr_port_if.port regPort
);
   logic [2:0] clkSync, next_clkSync;
   logic [1:0] selSync, next_selSync;
   logic [1:0] datSync, next_datSync;
   logic [4:0] count, next_count;
   logic [15:0] shift, next_shift;
   logic [15:0] outShift, next_outShift;
   logic [6:0] addr, next_addr;
   logic [15:0] wrData, next_wrData;
   logic isRead, next_isRead, wrStb, next_wrStb, loadPending, next_loadPending;
   logic next_sdioOut, next_sdioOe, rise, fall;

   // Frame decoding: read/write flag, seven address bits, sixteen data bits, MSB first.
   always_comb begin
      next_clkSync = {clkSync[1:0], serialClk};
      next_selSync = {selSync[0], chipSelectN};
      next_datSync = {datSync[0], sdioIn};
      rise = clkSync[1] & ~clkSync[2];
      fall = ~clkSync[1] & clkSync[2];
      next_count = count;
      next_shift = shift;
      next_outShift = outShift;
      next_addr = addr;
      next_wrData = wrData;
      next_isRead = isRead;
      next_wrStb = 1'b0;
      next_loadPending = 1'b0;
      next_sdioOut = sdioOut;
      next_sdioOe = sdioOe;
      if (selSync[1]) begin
         next_count = 5'h00;
         next_isRead = 1'b0;
         next_sdioOe = 1'b0;
      end else begin
         if (rise && count != FRAME_BITS) begin
            next_shift = {shift[14:0], datSync[1]};
            next_count = count + 5'h01;
            if (count == HEAD_BITS - 5'h01) begin
               next_addr = {shift[5:0], datSync[1]};
               next_isRead = shift[6];
               next_loadPending = 1'b1;
            end
            if (count == FRAME_BITS - 5'h01 && !isRead) begin
               next_wrData = {shift[14:0], datSync[1]};
               next_wrStb = 1'b1;
            end
         end
         if (loadPending) begin
            next_outShift = regPort.rdData;
         end
         if (fall && isRead && count >= HEAD_BITS && count < FRAME_BITS) begin
            next_sdioOut = outShift[15];
            next_outShift = {outShift[14:0], 1'b0};
            next_sdioOe = 1'b1;
         end
      end
   end

   // State registers.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         clkSync <= 3'h0;
         selSync <= 2'h3;
         datSync <= 2'h0;
         count <= 5'h00;
         shift <= 16'h0000;
         outShift <= 16'h0000;
         addr <= 7'h00;
         wrData <= 16'h0000;
         isRead <= 1'b0;
         wrStb <= 1'b0;
         loadPending <= 1'b0;
         sdioOut <= 1'b0;
         sdioOe <= 1'b0;
      end else begin
         clkSync <= next_clkSync;
         selSync <= next_selSync;
         datSync <= next_datSync;
         count <= next_count;
         shift <= next_shift;
         outShift <= next_outShift;
         addr <= next_addr;
         wrData <= next_wrData;
         isRead <= next_isRead;
         wrStb <= next_wrStb;
         loadPending <= next_loadPending;
         sdioOut <= next_sdioOut;
         sdioOe <= next_sdioOe;
      end
   end

   // Word side outputs.
   assign regPort.addr = addr;
   assign regPort.wrData = wrData;
   assign regPort.wrStb = wrStb;
endmodule

/* File: hw/mpr_control_regs.sv */
// Control word bank of the dual receive mixer and its frequency synthesizer.
// Assumes a host on the three-wire serial pins and one system clock.
`timescale 1ns/1ps
module mpr_control_regs import mpr_pkg::*; #(
   // Identification words; the values are arbitrary.
   parameter logic [15:0] REVISION_WORD = 16'h0a01,
   parameter logic [15:0] PRODUCT_WORD = 16'h0b02
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Serial pins.
   input wire logic serialClk,
   input wire logic chipSelectN,
   input wire logic sdioIn,
   output logic sdioOut,
   output logic sdioOe,
   // Restart strobe.
   output logic softRestart,
   // Power block_power_switches.
   output logic loRegulatorOn,
   output logic secondLoOn,
   output logic inputBalunOn,
   output logic firstLoOn,
   output logic dividerRegulatorOn,
   output logic [1:0] receiveChannelPower,
   output logic externalLoPathOn,
   output logic loDriverOn,
   output logic oscBufferRegulatorOn,
   output logic referenceBufferOn,
   output logic oscillatorsOn,
   output logic dividersOn,
   output logic pumpOn,
   output logic oscRegulatorOn,
   output logic mainRegulatorOn,
   // Synthesizer dividers.
   output logic integerMode,
   output logic [14:0] integerDivide,
   output logic [15:0] fractionNumerator,
   output logic [15:0] fractionModulus,
   // IF amplifier bias.
   output logic linearityDacEfficiencyMode,
   output logic mainDacEfficiencyMode,
   output logic [1:0] linearitySlope,
   output logic [1:0] mainSlope,
   output logic [3:0] linearityBiasLevel,
   output logic linearityBiasInternal,
   output logic [3:0] mainBiasLevel,
   output logic mainBiasInternal,
   // Charge pump and phase detector.
   output logic [5:0] pumpCurrentScale,
   output logic bleedPolarity,
   output logic [6:0] bleedMagnitude,
   output logic [7:0] referenceOutRoute,
   output logic detectorPolarity,
   output logic [11:0] referenceDivideRatio,
   output logic [2:0] pumpControlField,
   // Oscillator and LO.
   output logic [3:0] oscillatorCoreOn,
   output logic externalLoSelected,
   output logic [1:0] loDriveLevel,
   output logic [2:0] loDivide,
   // Mixer balun.
   output logic [2:0] mixerGateBias,
   output logic [2:0] mixerOutputFilter,
   output logic [3:0] balunOutputCapacitance
);
   // -----------------------------------------------------------------
   // Storage and serial port
   // -----------------------------------------------------------------
   logic [15:0] word [REG_COUNT];
   logic [15:0] next_word [REG_COUNT];
   logic next_softRestart;
   logic [3:0] next_oscillatorCoreOn;
   logic next_externalLoSelected;
   logic [7:0] next_referenceOutRoute;
   logic [2:0] oscSelect;
   logic [2:0] refSelect;

   // Word transfers between port and bank.
   mpr_port_if regLink ();

   mpr_serial_port serialPort (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .serialClk(serialClk),
      .chipSelectN(chipSelectN),
      .sdioIn(sdioIn),
      .sdioOut(sdioOut),
      .sdioOe(sdioOe),
      .regPort(regLink.port)
   );

   // Maps a word address to its slot in the bank, or -1 when unmapped.
   function automatic int regIndex(input logic [6:0] a);
      int found;
      found = -1;
      for (int i = 0; i < REG_COUNT; i++) begin
         if (REG_ADDR[i] == a) begin
            found = i;
         end
      end
      return found;
   endfunction

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   // The read value follows the held address; unmapped addresses read zero.
   always_comb begin
      int idx;
      idx = regIndex(regLink.addr);
      if (regLink.addr == ADDR_RESTART) begin
         regLink.rdData = 16'h0000;
      end else if (regLink.addr == ADDR_REVISION_B) begin
         regLink.rdData = REVISION_WORD;
      end else if (regLink.addr == ADDR_PRODUCT_B) begin
         regLink.rdData = PRODUCT_WORD;
      end else if (idx >= 0) begin
         regLink.rdData = word[idx];
      end else begin
         regLink.rdData = 16'h0000;
      end
   end

   // -----------------------------------------------------------------
   // Write path, restart and decoders
   // -----------------------------------------------------------------
   // Codes feeding the registered decoders.
   assign oscSelect = word[IDX_OSC][2:0];
   assign refSelect = word[IDX_PFDA][REF_OUT_LSB +: 3];

   // Next values of the bank, the restart strobe and the decoded selections.
   always_comb begin
      int idx;
      idx = regIndex(regLink.addr);
      next_softRestart = regLink.wrStb && (regLink.addr == ADDR_RESTART);
      for (int i = 0; i < REG_COUNT; i++) begin
         next_word[i] = softRestart ? REG_RESET[i] : word[i];
      end
      // Frames far outlast the restart pulse; a same-cycle write would win.
      if (regLink.wrStb && idx >= 0) begin
         next_word[idx] = regLink.wrData;
      end
      next_oscillatorCoreOn = 4'h0;
      if (!oscSelect[2]) begin
         next_oscillatorCoreOn[oscSelect[1:0]] = 1'b1;
      end
      next_externalLoSelected = (oscSelect == OSC_EXTERNAL);
      next_referenceOutRoute = 8'h01 << refSelect;
   end

   // Bank and decoder registers; the power-on reset loads the listed values.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         word <= REG_RESET;
         softRestart <= 1'b0;
         oscillatorCoreOn <= OSC_CORE_RESET;
         externalLoSelected <= 1'b0;
         referenceOutRoute <= REF_ROUTE_RESET;
      end else begin
         word <= next_word;
         softRestart <= next_softRestart;
         oscillatorCoreOn <= next_oscillatorCoreOn;
         externalLoSelected <= next_externalLoSelected;
         referenceOutRoute <= next_referenceOutRoute;
      end
   end

   // -----------------------------------------------------------------
   // Field outputs
   // -----------------------------------------------------------------
   // Each power function has its own bit; receive channel power takes two, bits 10:9.
   assign loRegulatorOn = word[IDX_POWER][PWR_LO_REG];
   assign secondLoOn = word[IDX_POWER][PWR_LO2];
   assign inputBalunOn = word[IDX_POWER][PWR_BALUN];
   assign firstLoOn = word[IDX_POWER][PWR_LO1];
   assign dividerRegulatorOn = word[IDX_POWER][PWR_DIV_REG];
   assign receiveChannelPower = word[IDX_POWER][PWR_RX_LSB +: 2];
   assign externalLoPathOn = word[IDX_POWER][PWR_EXT_LO];
   assign loDriverOn = word[IDX_POWER][PWR_LO_DRV];
   assign oscBufferRegulatorOn = word[IDX_POWER][PWR_OSC_BUF];
   assign referenceBufferOn = word[IDX_POWER][PWR_REF_BUF];
   assign oscillatorsOn = word[IDX_POWER][PWR_OSC];
   assign dividersOn = word[IDX_POWER][PWR_DIVIDERS];
   assign pumpOn = word[IDX_POWER][PWR_PUMP];
   assign oscRegulatorOn = word[IDX_POWER][PWR_OSC_REG];
   assign mainRegulatorOn = word[IDX_POWER][PWR_MAIN_REG];

   // Synthesizer divider settings.
   assign integerMode = word[IDX_INT][INT_MODE_BIT];
   assign integerDivide = word[IDX_INT][14:0];
   assign fractionNumerator = word[IDX_FRAC];
   assign fractionModulus = word[IDX_MOD];

   // IF amplifier bias settings.
   assign linearityDacEfficiencyMode = word[IDX_IFBIAS][IF_LIN_EFF_BIT];
   assign mainDacEfficiencyMode = word[IDX_IFBIAS][IF_MAIN_EFF_BIT];
   assign linearitySlope = word[IDX_IFBIAS][IF_LIN_SLOPE_LSB +: 2];
   assign mainSlope = word[IDX_IFBIAS][IF_MAIN_SLOPE_LSB +: 2];
   assign linearityBiasLevel = word[IDX_IFBIAS][IF_LIN_BIAS_LSB +: 4];
   assign linearityBiasInternal = word[IDX_IFBIAS][IF_LIN_INT_BIT];
   assign mainBiasLevel = word[IDX_IFBIAS][IF_MAIN_BIAS_LSB +: 4];
   assign mainBiasInternal = word[IDX_IFBIAS][IF_MAIN_INT_BIT];

   // Charge pump and phase detector settings; bits 15:14 of the pump word steer nothing.
   assign pumpCurrentScale = word[IDX_PUMP][PUMP_SCALE_LSB +: 6];
   assign bleedPolarity = word[IDX_PUMP][PUMP_BLEED_POL_BIT];
   assign bleedMagnitude = word[IDX_PUMP][6:0];
   assign detectorPolarity = word[IDX_PFDA][DET_POL_BIT];
   assign referenceDivideRatio = word[IDX_PFDA][11:0];
   assign pumpControlField = word[IDX_PFDB][PUMP_CTRL_LSB +: 3];

   // Oscillator and LO settings.
   assign loDriveLevel = word[IDX_OSC][LO_LEVEL_LSB +: 2];
   assign loDivide = word[IDX_OSC][LO_DIV_LSB +: 3];

   // Balun settings; one filter and one capacitance value serve both channels.
   assign mixerGateBias = word[IDX_BALUN][BAL_GATE_LSB +: 3];
   assign mixerOutputFilter = word[IDX_BALUN][BAL_FILTER_LSB +: 3];
   assign balunOutputCapacitance = word[IDX_BALUN][BALUN_OUTPUT_CAPACITANCE_LSB +: 4];

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // Single-word write strobes for the checks.
   logic wrPower, wrIfBias, wrPump;
   assign wrPower = regLink.wrStb && regLink.addr == REG_ADDR[IDX_POWER];
   assign wrIfBias = regLink.wrStb && regLink.addr == REG_ADDR[IDX_IFBIAS];
   assign wrPump = regLink.wrStb && regLink.addr == REG_ADDR[IDX_PUMP];
   logic wrInt, wrPfdA, wrBalun;
   assign wrInt = regLink.wrStb && regLink.addr == REG_ADDR[IDX_INT];
   assign wrPfdA = regLink.wrStb && regLink.addr == REG_ADDR[IDX_PFDA];
   assign wrBalun = regLink.wrStb && regLink.addr == REG_ADDR[IDX_BALUN];

   // Restart pulse and restart word.
   AST_RESTART_ON_WRITE: assert property (
      regLink.wrStb && regLink.addr == ADDR_RESTART |=> softRestart ##1 !softRestart)
      else $error("Write to restart word gave no single restart pulse.");
   AST_RESTART_READS_ZERO: assert property (
      regLink.addr == ADDR_RESTART |-> regLink.rdData == 16'h0000)
      else $error("Restart word did not read zero.");
   // Power block_power_switches follow their write.
   AST_CHANNEL_SELECT: assert property (
      wrPower |=> receiveChannelPower == $past(regLink.wrData[10:9]))
      else $error("Receive channel selection did not follow the write.");
   AST_POWER_BITS: assert property (
      wrPower |=> {loRegulatorOn, secondLoOn, inputBalunOn, mainRegulatorOn}
         == {$past(regLink.wrData[15:13]), $past(regLink.wrData[0])})
      else $error("Power block_power_switches did not follow the write.");

   // Restart reloads the listed values; the bias mode bits follow their write.
   AST_DIVIDER_RESTART: assert property (
      softRestart |=> !integerMode && integerDivide == 15'h0058
         && fractionNumerator == 16'h0250 && fractionModulus == 16'h0600)
      else $error("Divider words not restored by restart.");
   AST_BIAS_MODE: assert property (
      wrIfBias |=> {linearityDacEfficiencyMode, mainDacEfficiencyMode}
         == $past(regLink.wrData[15:14]))
      else $error("Bias mode bits did not follow the write.");
   AST_BIAS_RESTART: assert property (
      softRestart |=> linearityBiasLevel == 4'ha && mainBiasLevel == 4'ha
         && linearityBiasInternal && mainBiasInternal)
      else $error("IF bias fields not restored by restart.");
   AST_PUMP_RESTART: assert property (
      softRestart |=> bleedMagnitude == 7'h26 && pumpCurrentScale == 6'h00
         && referenceDivideRatio == 12'h003 && pumpControlField == 3'h4)
      else $error("Pump and detector fields not restored by restart.");

   // Decoders trail their code by one cycle; balun fields restart to zero; the pump word reads back.
   AST_REF_ROUTE: assert property (
      referenceOutRoute == (8'h01 << $past(refSelect)))
      else $error("Reference output route does not match its code.");
   AST_OSC_DECODE: assert property (
      $past(oscSelect) == OSC_EXTERNAL |-> externalLoSelected && oscillatorCoreOn == 4'h0)
      else $error("External LO selection decoded wrongly.");
   AST_BALUN_RESTART: assert property (
      softRestart |=> mixerGateBias == 3'h0 && mixerOutputFilter == 3'h0
         && balunOutputCapacitance == 4'h0)
      else $error("Balun fields not restored by restart.");
   AST_UNUSED_READBACK: assert property (
      wrPump ##1 regLink.addr == REG_ADDR[IDX_PUMP] |-> regLink.rdData == $past(regLink.wrData))
      else $error("Pump word did not read back the value written.");

   // Writes of single fields land one cycle after the strobe.
   AST_INT_MODE: assert property (
      wrInt |=> integerMode == $past(regLink.wrData[15])
         && integerDivide == $past(regLink.wrData[14:0]))
      else $error("Integer word did not follow the write.");
   AST_DETECTOR_WRITE: assert property (
      wrPfdA |=> {detectorPolarity, referenceDivideRatio} == $past(regLink.wrData[12:0]))
      else $error("Detector word did not follow the write.");
   AST_SHARED_FILTER: assert property (
      wrBalun |=> mixerOutputFilter == $past(regLink.wrData[10:8])
         && balunOutputCapacitance == $past(regLink.wrData[7:4]))
      else $error("Shared balun fields did not follow the write.");

   // Codes 0 to 3 light one core; the upper codes light none.
   AST_CORE_DECODE: assert property (
      !$past(oscSelect[2]) |-> oscillatorCoreOn == 4'h1 << $past(oscSelect[1:0]))
      else $error("Oscillator core decoded wrongly.");
   AST_NO_CORE: assert property (
      $past(oscSelect[2]) |-> oscillatorCoreOn == 4'h0)
      else $error("Upper oscillator code lit a core.");

   // Restart powers every block down; identity words stay fixed.
   AST_POWER_RESTART: assert property (
      softRestart |=> receiveChannelPower == 2'h0 && !loRegulatorOn
         && !pumpOn && !mainRegulatorOn)
      else $error("Power word not cleared by restart.");
   AST_ID_READ: assert property (
      regLink.addr == ADDR_REVISION_B |-> regLink.rdData == REVISION_WORD)
      else $error("Revision word read wrongly.");

   // Scenarios the bench should reach.
   COV_RESTART: cover property (regLink.wrStb && regLink.addr == ADDR_RESTART);
   COV_EXT_LO: cover property (externalLoSelected);
   COV_BOTH_CHANNELS: cover property (receiveChannelPower == 2'h3);
   COV_READ_OUT: cover property (sdioOe);
   COV_INT_MODE: cover property (integerMode);
endmodule

/* File: verif/mpr_host_model.sv */
// Serial host model that frames words onto the three-wire port.
// Assumes the bench clock; every serial phase lasts five sys_clk cycles.
`timescale 1ns/1ps
module mpr_host_model (
   // Clock.
   input wire logic sys_clk,
   // Serial pins.
   input wire logic sdioOut,
   output logic serialClk,
   output logic chipSelectN,
   output logic sdioIn
);
   // The pins idle with the frame deselected and the clock low.
   initial begin
      serialClk = 1'b0;
      chipSelectN = 1'b1;
      sdioIn = 1'b0;
   end
   // Sends n bits, MSB first; a read releases the pin after the header.
   task automatic frame(input logic rw, input logic [6:0] a, input logic [15:0] d,
      input int n, output logic [15:0] q);
      logic [23:0] f;
      f = {rw, a, d};
      q = 16'h0000;
      @(posedge sys_clk);
      #1 chipSelectN = 1'b0;
      sdioIn = f[23];
      for (int i = 23; i >= 24 - n; i--) begin
         repeat (5) @(posedge sys_clk);
         q[i % 16] = sdioOut;
         #1 serialClk = 1'b1;
         repeat (5) @(posedge sys_clk);
         #1 serialClk = 1'b0;
         // A released pin shows the inverse, never a stale bit.
         sdioIn = (i == 0 || (rw && i <= 16)) ? ~sdioIn : f[i-1];
      end
      repeat (5) @(posedge sys_clk);
      #1 chipSelectN = 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the control word bank behind its serial pins.
// Assumes the host model drives the pins; expectations come from the bench.
`timescale 1ns/1ps
`define CHK(n, s, e) begin checks++; if ((s) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench import mpr_pkg::*; ;
   localparam logic [15:0] REV = 16'h5a3c; // Arbitrary identification value.
   localparam logic [15:0] PRD = 16'h3c5a; // Arbitrary identification value.
   logic sys_clk, rstn, serialClk, chipSelectN, sdioIn, sdioOut, sdioOe, softRestart;
   logic loRegulatorOn, secondLoOn, inputBalunOn, firstLoOn, dividerRegulatorOn;
   logic externalLoPathOn, loDriverOn, oscBufferRegulatorOn, referenceBufferOn;
   logic oscillatorsOn, dividersOn, pumpOn, oscRegulatorOn, mainRegulatorOn, integerMode;
   logic linearityDacEfficiencyMode, mainDacEfficiencyMode, linearityBiasInternal;
   logic mainBiasInternal, bleedPolarity, detectorPolarity, externalLoSelected;
   logic [1:0] receiveChannelPower, linearitySlope, mainSlope, loDriveLevel;
   logic [2:0] pumpControlField, loDivide, mixerGateBias, mixerOutputFilter;
   logic [3:0] linearityBiasLevel, mainBiasLevel, oscillatorCoreOn, balunOutputCapacitance;
   logic [5:0] pumpCurrentScale;
   logic [6:0] bleedMagnitude;
   logic [7:0] referenceOutRoute;
   logic [11:0] referenceDivideRatio;
   logic [14:0] integerDivide;
   logic [15:0] fractionNumerator, fractionModulus, q;
   logic [15:0] m [REG_COUNT];
   int mismatches, checks, pulses, p, oes;

   mpr_control_regs #(.REVISION_WORD(REV), .PRODUCT_WORD(PRD)) u_mpr_control_regs (.*);
   mpr_host_model u_mpr_host_model (.*);

   // Clock at 250 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Counts one-cycle restart pulses and cycles with the data pin driven.
   always @(posedge sys_clk) begin
      if (softRestart === 1'b1) pulses++;
      if (sdioOe === 1'b1) oes++;
   end
   // A hang is cut short well beyond the expected run.
   initial begin
      #400000;
      mismatches++;
      complete_run();
   end

   // Expected core block_power_switches for an oscillator select code.
   function automatic logic [3:0] core(input logic [2:0] s);
      return s[2] ? 4'h0 : 4'h1 << s[1:0];
   endfunction
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      u_mpr_host_model.frame(1'b0, a, d, 24, q);
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      int o;
      o = oes;
      u_mpr_host_model.frame(1'b1, a, 16'h0000, 24, q);
      `CHK("readback", q, e)
      `CHK("oe", {oes > o, sdioOe}, 2'b10)
   endtask
   task automatic rdall();
      for (int i = 0; i < REG_COUNT; i++) rd(REG_ADDR[i], m[i]);
   endtask
   // Compares every field output with the bench copy of the words.
   task automatic ports();
      `CHK("power", {loRegulatorOn, secondLoOn, inputBalunOn, firstLoOn, dividerRegulatorOn,
         receiveChannelPower, externalLoPathOn, loDriverOn, oscBufferRegulatorOn,
         referenceBufferOn, oscillatorsOn, dividersOn, pumpOn, oscRegulatorOn,
         mainRegulatorOn}, m[IDX_POWER])
      `CHK("int", {integerMode, integerDivide}, m[IDX_INT])
      `CHK("frac", fractionNumerator, m[IDX_FRAC])
      `CHK("mod", fractionModulus, m[IDX_MOD])
      `CHK("ifbias", {linearityDacEfficiencyMode, mainDacEfficiencyMode, linearitySlope,
         mainSlope, linearityBiasLevel, linearityBiasInternal, mainBiasLevel,
         mainBiasInternal}, m[IDX_IFBIAS])
      `CHK("pump", {pumpCurrentScale, bleedPolarity, bleedMagnitude}, m[IDX_PUMP][13:0])
      `CHK("route", referenceOutRoute, 8'h01 << m[IDX_PFDA][15:13])
      `CHK("det", {detectorPolarity, referenceDivideRatio}, m[IDX_PFDA][12:0])
      `CHK("core", oscillatorCoreOn, core(m[IDX_OSC][2:0]))
      `CHK("extlo", externalLoSelected, m[IDX_OSC][2:0] == OSC_EXTERNAL)
      `CHK("lo", {loDriveLevel, loDivide}, m[IDX_OSC][7:3])
      `CHK("balun", {mixerGateBias, mixerOutputFilter, balunOutputCapacitance},
         m[IDX_BALUN][13:4])
      `CHK("pctl", pumpControlField, m[IDX_PFDB][4:2])
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence: reset values, random words, every code, refusals, restart.
   initial begin
      rstn = 1'b0;
      void'($urandom(32'hf9bd));
      repeat (10) @(posedge sys_clk);
      #1 rstn = 1'b1;
      repeat (4) @(posedge sys_clk);
      m = REG_RESET;
      ports();
      rdall();
      rd(ADDR_RESTART, 16'h0000);
      rd(ADDR_PRODUCT_B, PRD);
      $display("test reset done");
      for (int i = 0; i < REG_COUNT; i++) begin
         m[i] = 16'($urandom());
         if (i == IDX_BALUN) m[i][3:0] = 4'h0;
         wr(REG_ADDR[i], m[i]);
      end
      rdall();
      ports();
      $display("test random done");
      for (int c = 0; c < 8; c++) begin
         m[IDX_POWER][10:9] = c[1:0];
         m[IDX_PFDA][15:13] = c[2:0];
         m[IDX_OSC][2:0] = c[2:0];
         wr(REG_ADDR[IDX_POWER], m[IDX_POWER]);
         wr(REG_ADDR[IDX_PFDA], m[IDX_PFDA]);
         wr(REG_ADDR[IDX_OSC], m[IDX_OSC]);
         ports();
      end
      $display("test codes done");
      wr(7'h05, 16'hffff);
      rd(7'h05, 16'h0000);
      wr(ADDR_REVISION_B, ~REV);
      rd(ADDR_REVISION_B, REV);
      u_mpr_host_model.frame(1'b0, REG_ADDR[IDX_INT], ~m[IDX_INT], 20, q);
      rd(REG_ADDR[IDX_INT], m[IDX_INT]);
      $display("test refusals done");
      p = pulses;
      wr(ADDR_RESTART, 16'($urandom()));
      `CHK("pulses", pulses, p + 1)
      m = REG_RESET;
      rdall();
      ports();
      $display("test restart done");
      complete_run();
   end
endmodule
